// ===== tpc_defines.svh
// register offsets, field positions, reset values and clock ratios for the timer pin select / compact timer block
// assumes wishbone byte-per-word register map, 32-bit data bus
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_OFS_PINSEL_A 6'h00
`define TPC_OFS_PINSEL_B 6'h04
`define TPC_OFS_CTRL0 6'h08
`define TPC_OFS_CTRL1 6'h0C
`define TPC_OFS_CNT_LO 6'h10
`define TPC_OFS_CNT_HI 6'h14
`define TPC_OFS_CMPA_LO 6'h18
`define TPC_OFS_CMPA_HI 6'h1C
`define TPC_OFS_INV 6'h20
`define TPC_OFS_STATUS 6'h24
`define TPC_PINSEL_A_MASK 8'hFF
`define TPC_PINSEL_B_MASK 8'h07
`define TPC_RESET_BYTE 8'h00
`define TPC_CTRL0_PAUSE 7
`define TPC_CTRL0_ENABLE 3
`define TPC_CTRL1_CCLR 0
`define TPC_CTRL1_POL 2
`define TPC_CTRL1_OINIT 3
`define TPC_DIV_FSYS4 4
`define TPC_DIV_FH16 16
`define TPC_DIV_FH64 64
`define TPC_DIV_FSUB 256
`endif

// ===== tpc_pkg.sv
// types for the timer pin select / compact timer block
// assumes tpc_defines.svh for numeric constants
package tpc_pkg;
	typedef enum logic [1:0] {
		TPC_MODE_CMP_OUT,
		TPC_MODE_UNDEF,
		TPC_MODE_PWM,
		TPC_MODE_TIMER
	} tpc_mode_e;
	typedef enum logic [2:0] {
		TPC_CK_FSYS4,
		TPC_CK_FSYS,
		TPC_CK_FH16,
		TPC_CK_FH64,
		TPC_CK_FSUB,
		TPC_CK_NONE,
		TPC_CK_PIN_RISE,
		TPC_CK_PIN_FALL
	} tpc_clksel_e;
	typedef logic [9:0] tpc_count_t;
endpackage

// ===== tpc_core.sv
// timer pin select registers, buffered byte access and the compact 10-bit timer core
// assumes classic wishbone slave, one clock, external pin clock arrives asynchronously
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tpc_defines.svh"

// Contract
// - set pin select bit routes pin to timer
// - unimplemented select bits read zero, ignore writes
// - port data bits invert each output pin (code: only group a pins routed to a timer; group b pins are never inverted)
// - ten-bit values split, low via buffer
// - compare low write loads buffer only
// - compare high write also copies buffer low
// - high read returns high, latches low
// - low read returns holding buffer
// - ten-bit up counter, selectable clock source
// - period compare against top three bits
// - compare A against all ten bits
// - counter cleared by software only via enable rising
// - overflow or match clears counter, interrupt
// - compare output, timer, and pwm modes
// - several outputs, same or inverted signal
// - pin clock counts rising or falling edge
// - period zero means run to overflow
module tpc_core #(
	parameter int NUM_PINS_A = 8,
	parameter int NUM_PINS_B = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fh_tick_i,
	input wire logic fsub_tick_i,
	input wire logic ext_clk_pin_i,
	input wire logic [NUM_PINS_A-1:0] pin_alt_a_i,
	input wire logic [NUM_PINS_B-1:0] pin_alt_b_i,
	input wire logic [NUM_PINS_B-1:0] timer2_out_i,
	input wire logic [4:0] timer1_out_i,
	output logic [NUM_PINS_A-1:0] pin_out_a_o,
	output logic [NUM_PINS_B-1:0] pin_out_b_o,
	output logic [NUM_PINS_A-1:0] pin_sel_a_o,
	output logic [NUM_PINS_B-1:0] pin_sel_b_o,
	output logic timer_irq_a_o,
	output logic timer_irq_p_o
);
	import tpc_pkg::*;

	// the pin maps below are written for exactly these group widths
	if (NUM_PINS_A != 8 || NUM_PINS_B != 3) begin : g_bad_pins
		$error("tpc_core: pin counts must be 8 and 3");
	end

	logic [7:0] pin_select_reg_a;
	logic [7:0] pin_select_reg_b;
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] inv_reg;
	logic [7:0] hold_reg;
	logic [9:0] cmpa_reg;
	tpc_count_t cnt_reg;
	logic out_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic en_d_reg;
	logic [2:0] ext_sync_reg;
	logic ext_last_reg;
	logic [7:0] div_reg;
	logic [7:0] fh_div_reg;
	logic [1:0] sticky_reg;

	// bus decode
	wire req = wb_cyc_i && wb_stb_i && !ack_reg;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire rd = req && !wb_we_i;
	wire hit_psa = wb_adr_i == `TPC_OFS_PINSEL_A;
	wire hit_psb = wb_adr_i == `TPC_OFS_PINSEL_B;
	wire hit_c0 = wb_adr_i == `TPC_OFS_CTRL0;
	wire hit_c1 = wb_adr_i == `TPC_OFS_CTRL1;
	wire hit_dl = wb_adr_i == `TPC_OFS_CNT_LO;
	wire hit_dh = wb_adr_i == `TPC_OFS_CNT_HI;
	wire hit_al = wb_adr_i == `TPC_OFS_CMPA_LO;
	wire hit_ah = wb_adr_i == `TPC_OFS_CMPA_HI;
	wire hit_inv = wb_adr_i == `TPC_OFS_INV;
	wire hit_st = wb_adr_i == `TPC_OFS_STATUS;

	wire timer_en = ctrl0_reg[`TPC_CTRL0_ENABLE];
	wire pause = ctrl0_reg[`TPC_CTRL0_PAUSE];
	wire [2:0] period = ctrl0_reg[2:0];
	wire [2:0] clksel_raw = ctrl0_reg[6:4];
	tpc_clksel_e clksel;
	assign clksel = tpc_clksel_e'(clksel_raw);
	wire [1:0] mode_raw = ctrl1_reg[7:6];
	tpc_mode_e mode;
	assign mode = tpc_mode_e'(mode_raw);
	wire [1:0] io_sel = ctrl1_reg[5:4];
	wire cclr = ctrl1_reg[`TPC_CTRL1_CCLR];

	// read mux: low bytes always return the holding buffer
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit_psa)
			rd_byte = pin_select_reg_a & `TPC_PINSEL_A_MASK;
		else if (hit_psb)
			rd_byte = pin_select_reg_b & `TPC_PINSEL_B_MASK;
		else if (hit_c0)
			rd_byte = ctrl0_reg;
		else if (hit_c1)
			rd_byte = ctrl1_reg;
		else if (hit_dl || hit_al)
			rd_byte = hold_reg;
		else if (hit_dh)
			rd_byte = {6'h00, cnt_reg[9:8]};
		else if (hit_ah)
			rd_byte = {6'h00, cmpa_reg[9:8]};
		else if (hit_inv)
			rd_byte = inv_reg;
		else if (hit_st)
			rd_byte = {5'h00, out_reg, sticky_reg};
	end

	// one-cycle ack, one byte per access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (rd)
				rdat_reg <= {24'h00_0000, rd_byte};
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_select_reg_a <= `TPC_RESET_BYTE;
			pin_select_reg_b <= `TPC_RESET_BYTE;
			ctrl0_reg <= `TPC_RESET_BYTE;
			ctrl1_reg <= `TPC_RESET_BYTE;
			inv_reg <= `TPC_RESET_BYTE;
		end else if (wr) begin
			if (hit_psa)
				pin_select_reg_a <= wb_dat_i[7:0] & `TPC_PINSEL_A_MASK;
			if (hit_psb)
				pin_select_reg_b <= wb_dat_i[7:0] & `TPC_PINSEL_B_MASK;
			if (hit_c0)
				ctrl0_reg <= wb_dat_i[7:0];
			if (hit_c1)
				ctrl1_reg <= wb_dat_i[7:0];
			if (hit_inv)
				inv_reg <= wb_dat_i[7:0];
		end
	end

	// shared holding buffer and compare value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_reg <= 8'h00;
			cmpa_reg <= 10'h000;
		end else begin
			if (wr && hit_al)
				hold_reg <= wb_dat_i[7:0];
			else if (rd && hit_dh)
				hold_reg <= cnt_reg[7:0];
			else if (rd && hit_ah)
				hold_reg <= cmpa_reg[7:0];
			if (wr && hit_ah)
				cmpa_reg <= {wb_dat_i[1:0], hold_reg};
		end
	end

	// external clock pin: three flops, edge counts when the later two agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_reg <= 3'h0;
			ext_last_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_pin_i};
			if (ext_sync_reg[2] == ext_sync_reg[1])
				ext_last_reg <= ext_sync_reg[2];
		end
	end
	wire ext_stable = ext_sync_reg[2] == ext_sync_reg[1];
	wire ext_rise = ext_stable && ext_sync_reg[2] && !ext_last_reg;
	wire ext_fall = ext_stable && !ext_sync_reg[2] && ext_last_reg;

	// internal dividers; fh and fsub are one-cycle enables from the clock unit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			fh_div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
			if (fh_tick_i)
				fh_div_reg <= fh_div_reg + 8'h01;
		end
	end

	logic tick;
	always_comb begin
		unique case (clksel)
			TPC_CK_FSYS4: tick = div_reg[1:0] == 2'h3;
			TPC_CK_FSYS: tick = 1'b1;
			TPC_CK_FH16: tick = fh_tick_i && fh_div_reg[3:0] == 4'hF;
			TPC_CK_FH64: tick = fh_tick_i && fh_div_reg[5:0] == 6'h3F;
			TPC_CK_FSUB: tick = fsub_tick_i;
			TPC_CK_NONE: tick = 1'b0;
			TPC_CK_PIN_RISE: tick = ext_rise;
			TPC_CK_PIN_FALL: tick = ext_fall;
		endcase
	end

	// comparators
	wire match_p = (period == 3'h0) ? (cnt_reg == 10'h3FF) : (cnt_reg[9:7] == period);
	wire match_a = cnt_reg == cmpa_reg;
	wire overflow = cnt_reg == 10'h3FF;
	wire clr_evt = cclr ? match_a : match_p;
	wire step = timer_en && !pause && tick;
	wire en_rise = timer_en && !en_d_reg;

	// counter: software can only clear it through the enable rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 10'h000;
			en_d_reg <= 1'b0;
		end else begin
			en_d_reg <= timer_en;
			if (en_rise)
				cnt_reg <= 10'h000;
			else if (step)
				cnt_reg <= (clr_evt || overflow) ? 10'h000 : cnt_reg + 10'h001;
		end
	end

	// match pulses; pwm duty is compare A against a period set by P
	wire evt_a = step && match_a;
	wire evt_p = step && (match_p || overflow);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_reg <= 1'b0;
			timer_irq_a_o <= 1'b0;
			timer_irq_p_o <= 1'b0;
			sticky_reg <= 2'h0;
		end else begin
			timer_irq_a_o <= evt_a;
			timer_irq_p_o <= evt_p;
			if (wr && hit_st)
				sticky_reg <= (sticky_reg & ~wb_dat_i[1:0]) | {evt_p, evt_a};
			else
				sticky_reg <= sticky_reg | {evt_p, evt_a};
			if (en_rise)
				out_reg <= ctrl1_reg[`TPC_CTRL1_OINIT];
			else
				unique case (mode)
					TPC_MODE_CMP_OUT: begin
						if (evt_a && io_sel == 2'h1)
							out_reg <= 1'b0;
						else if (evt_a && io_sel == 2'h2)
							out_reg <= 1'b1;
						else if (evt_a && io_sel == 2'h3)
							out_reg <= ~out_reg;
					end
					TPC_MODE_PWM: begin
						if (io_sel == 2'h0)
							out_reg <= 1'b0;
						else if (io_sel == 2'h1)
							out_reg <= 1'b1;
						else if (io_sel == 2'h2)
							out_reg <= timer_en && (cnt_reg < cmpa_reg);
					end
					TPC_MODE_TIMER: out_reg <= 1'b0;
					TPC_MODE_UNDEF: out_reg <= out_reg;
				endcase
		end
	end

	// polarity then per-pin inversion; timer 0 drives pins 0..2 of group a
	wire tm0_sig = out_reg ^ ctrl1_reg[`TPC_CTRL1_POL];
	wire [7:0] func_a = {timer1_out_i, {3{tm0_sig}}};
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS_A; gi++) begin : g_pa
			assign pin_out_a_o[gi] = pin_select_reg_a[gi] ? (func_a[gi] ^ inv_reg[gi]) : pin_alt_a_i[gi];
		end
		for (gi = 0; gi < NUM_PINS_B; gi++) begin : g_pb
			assign pin_out_b_o[gi] = pin_select_reg_b[gi] ? timer2_out_i[gi] : pin_alt_b_i[gi];
		end
	endgenerate
	assign pin_sel_a_o = pin_select_reg_a;
	assign pin_sel_b_o = pin_select_reg_b[NUM_PINS_B-1:0];

	// assertions
	sequence s_hi_read;
		rd && (hit_dh || hit_ah);
	endsequence
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	a_psb_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) pin_select_reg_b[7:3] == 5'h00)
		else $error("pin select b upper bits set");
	a_lo_write_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_al |=> hold_reg == $past(wb_dat_i[7:0]) && $stable(cmpa_reg))
		else $error("low write changed compare");
	a_hi_write_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_ah |=> cmpa_reg == {$past(wb_dat_i[1:0]), $past(hold_reg)})
		else $error("high write did not merge buffer");
	a_hi_read_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		s_hi_read |=> hold_reg == ($past(hit_dh) ? $past(cnt_reg[7:0]) : $past(cmpa_reg[7:0])))
		else $error("high read did not latch low");
	a_lo_read_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && (hit_dl || hit_al) |=> wb_dat_o == {24'h00_0000, $past(hold_reg)})
		else $error("low read not from buffer");
	a_en_rise_clear: assert property (@(posedge clk_i) disable iff (rst_i) en_rise |=> cnt_reg == 10'h000)
		else $error("counter not cleared on enable");
	a_match_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		step && !en_rise && (overflow || clr_evt) |=> cnt_reg == 10'h000 && timer_irq_p_o | timer_irq_a_o | !overflow)
		else $error("counter not cleared on match");
	a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		step && !en_rise && !overflow && !clr_evt |=> cnt_reg == $past(cnt_reg) + 10'h001)
		else $error("counter did not step");
	a_pin_select: assert property (@(posedge clk_i) disable iff (rst_i)
		!pin_select_reg_a[0] |-> pin_out_a_o[0] == pin_alt_a_i[0])
		else $error("unselected pin not alternate");
	a_oinit_load: assert property (@(posedge clk_i) disable iff (rst_i)
		en_rise |=> out_reg == $past(ctrl1_reg[`TPC_CTRL1_OINIT]))
		else $error("output not set to initial level");
	a_pwm_level: assert property (@(posedge clk_i) disable iff (rst_i)
		mode == TPC_MODE_PWM && io_sel == 2'h2 && timer_en && !en_rise
		|=> out_reg == ($past(cnt_reg) < $past(cmpa_reg)))
		else $error("pwm level does not follow compare");
	a_pin_invert: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_select_reg_a[0] |-> pin_out_a_o[0] == (tm0_sig ^ inv_reg[0]))
		else $error("selected pin ignores inversion");
endmodule

// ===== tpc_core_tb.sv
// self-checking bench for the pin select registers and compact timer core
// assumes tpc_core is driven directly: no partner model, wishbone driven here
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_core_tb;
	import tpc_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, ext, fh, fsub, irq_a, irq_p;
	logic [5:0] adr;
	logic [31:0] dw, dr;
	logic [7:0] alt_a, out_a, sel_a;
	logic [2:0] alt_b, t2, out_b, sel_b;
	logic [4:0] t1;
	logic [3:0] sel;
	logic [9:0] v;
	int miscompares, checked, g, g2;
	tpc_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .fh_tick_i(fh), .fsub_tick_i(fsub),
		.ext_clk_pin_i(ext), .pin_alt_a_i(alt_a), .pin_alt_b_i(alt_b), .timer2_out_i(t2), .timer1_out_i(t1),
		.pin_out_a_o(out_a), .pin_out_b_o(out_b), .pin_sel_a_o(sel_a), .pin_sel_b_o(sel_b),
		.timer_irq_a_o(irq_a), .timer_irq_p_o(irq_p));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk(ack, 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic rd10(input logic [5:0] hi, output logic [9:0] r);
		logic [31:0] qh, ql;
		wb(1'b0, hi, 8'h00, qh);
		wb(1'b0, hi - 6'h04, 8'h00, ql);
		r = {qh[1:0], ql[7:0]};
	endtask
	// gap in clocks between two successive pulses of one interrupt line
	task automatic gap(input logic p, output int r);
		int n;
		n = 0;
		r = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((p ? irq_p : irq_a) !== 1'b1 && n < 3000);
		do begin
			@(posedge clk_i);
			r++;
		end while ((p ? irq_p : irq_a) !== 1'b1 && r < 3000);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_i);
			ext <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
	endtask
	task automatic t_pins();
		rd(`TPC_OFS_PINSEL_A, 32'h0);
		rd(`TPC_OFS_PINSEL_B, 32'h0);
		wr(`TPC_OFS_PINSEL_B, 8'hFF);
		rd(`TPC_OFS_PINSEL_B, 32'h7);
		chk(sel_b, 3'h7);
		rd(6'h3C, 32'h0);
		alt_a <= 8'h5A;
		t1 <= 5'h15;
		alt_b <= 3'h2;
		t2 <= 3'h5;
		wr(`TPC_OFS_PINSEL_A, 8'hF8);
		chk(sel_a, 8'hF8);
		chk(out_a[7:3], 5'h15);
		chk(out_a[2:0], 3'h2);
		chk(out_b, 3'h5);
		wr(`TPC_OFS_INV, 8'hF8);
		chk(out_a[7:3], 5'h0A);
		wr(`TPC_OFS_PINSEL_A, 8'hFF);
		wr(`TPC_OFS_INV, 8'h02);
		chk(out_a[0] ^ out_a[1], 1'b1);
		chk(out_a[0] ^ out_a[2], 1'b0);
		wr(`TPC_OFS_PINSEL_B, 8'h00);
		chk(out_b, 3'h2);
		wr(`TPC_OFS_PINSEL_A, 8'h00);
		chk(out_a, 8'h5A);
		sel <= 4'hE;
		wr(`TPC_OFS_PINSEL_A, 8'h81);
		sel <= 4'hF;
		rd(`TPC_OFS_PINSEL_A, 32'h0);
	endtask
	task automatic t_buffer();
		wr(`TPC_OFS_CMPA_LO, 8'h34);
		rd(`TPC_OFS_CMPA_HI, 32'h0);
		rd(`TPC_OFS_CMPA_LO, 32'h0);
		wr(`TPC_OFS_CMPA_LO, 8'h34);
		wr(`TPC_OFS_CMPA_HI, 8'h02);
		rd(`TPC_OFS_CMPA_HI, 32'h2);
		rd(`TPC_OFS_CMPA_LO, 32'h34);
		wr(`TPC_OFS_CMPA_LO, 8'h77);
		rd(`TPC_OFS_CMPA_LO, 32'h77);
	endtask
	task automatic t_pinclk();
		wr(`TPC_OFS_CTRL1, 8'h00);
		wr(`TPC_OFS_CTRL0, 8'h68);
		pulses(5);
		wr(`TPC_OFS_CTRL0, 8'h60);
		rd10(`TPC_OFS_CNT_HI, v);
		chk(v, 10'h005);
		wr(`TPC_OFS_CTRL0, 8'h78);
		pulses(3);
		wr(`TPC_OFS_CTRL0, 8'h70);
		rd10(`TPC_OFS_CNT_HI, v);
		chk(v, 10'h003);
	endtask
	task automatic t_irq();
		wr(`TPC_OFS_CMPA_LO, 8'h10);
		wr(`TPC_OFS_CMPA_HI, 8'h00);
		wr(`TPC_OFS_CTRL1, 8'h01);
		wr(`TPC_OFS_CTRL0, 8'h18);
		gap(1'b0, g);
		chk(32'(g >= 16 && g <= 17), 32'h1);
		wr(`TPC_OFS_CTRL0, 8'h10);
		wr(`TPC_OFS_CTRL1, 8'h00);
		wr(`TPC_OFS_CTRL0, 8'h19);
		gap(1'b1, g);
		chk(32'(g >= 128 && g <= 129), 32'h1);
		gap(1'b0, g2);
		chk(g2, g);
		wr(`TPC_OFS_CTRL0, 8'h10);
		wr(`TPC_OFS_CTRL0, 8'h18);
		gap(1'b1, g);
		chk(g, 1024);
		wr(`TPC_OFS_CTRL0, 8'h10);
	endtask
	// ticks of one clock selection over an enabled window of 42 edges
	task automatic count_for(input logic [7:0] c0, output logic [9:0] r);
		wr(`TPC_OFS_CTRL0, c0);
		repeat (40) @(posedge clk_i);
		wr(`TPC_OFS_CTRL0, c0 & 8'hF7);
		rd10(`TPC_OFS_CNT_HI, r);
	endtask
	task automatic t_modes();
		int n;
		wr(`TPC_OFS_PINSEL_A, 8'h01);
		wr(`TPC_OFS_INV, 8'h00);
		wr(`TPC_OFS_CTRL1, 8'h39);
		wr(`TPC_OFS_CTRL0, 8'h18);
		gap(1'b0, g);
		chk(g, 32'h11);
		chk(out_a[0], 1'b1);
		repeat (17) @(posedge clk_i);
		chk(out_a[0], 1'b0);
		rd(`TPC_OFS_STATUS, 32'h3);
		wr(`TPC_OFS_STATUS, 8'h03);
		rd(`TPC_OFS_STATUS, 32'h0);
		wr(`TPC_OFS_CTRL1, 8'h29);
		gap(1'b0, g);
		chk(out_a[0], 1'b1);
		wr(`TPC_OFS_CTRL1, 8'h19);
		gap(1'b0, g);
		chk(out_a[0], 1'b0);
		wr(`TPC_OFS_CTRL1, 8'h1D);
		chk(out_a[0], 1'b1);
		wr(`TPC_OFS_CTRL0, 8'h10);
		wr(`TPC_OFS_CTRL1, 8'hA0);
		wr(`TPC_OFS_CTRL0, 8'h19);
		gap(1'b1, g);
		n = 0;
		repeat (129) begin
			@(posedge clk_i);
			if (out_a[0] === 1'b1)
				n++;
		end
		chk(n, 32'h10);
		wr(`TPC_OFS_CTRL1, 8'hC0);
		chk(out_a[0], 1'b0);
		wr(`TPC_OFS_CTRL0, 8'h10);
		count_for(8'h08, v);
		chk(32'(v >= 10 && v <= 11), 32'h1);
		count_for(8'h28, v);
		chk(32'(v >= 1 && v <= 2), 32'h1);
		count_for(8'h48, v);
		chk(v, 10'h015);
		count_for(8'h58, v);
		chk(v, 10'h000);
		count_for(8'h98, v);
		chk(v, 10'h000);
	endtask
	task automatic conclude();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// slow internal tick sources keep the other clock selections alive
	initial begin
		fh = 1'b0;
		fsub = 1'b0;
		forever @(posedge clk_i) begin
			fh <= ~fh;
			fsub <= fh & ~fsub;
		end
	end
	initial begin
		{cyc, stb, we, ext} = 4'h0;
		sel = 4'hF;
		adr = 6'h00;
		dw = 32'h0;
		{alt_a, alt_b, t1, t2} = 19'h0;
		miscompares = 0;
		checked = 0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_pins();
		t_buffer();
		t_pinclk();
		t_irq();
		t_modes();
		conclude();
	end
	initial begin
		#120000;
		miscompares++;
		conclude();
	end
endmodule
